/* src/iocp_defs.vh */
// constants for the sixteen-port card register map
// assumes a 10 MHz system clock
`ifndef IOCP_DEFS_VH
`define IOCP_DEFS_VH

// ==========================================
// port offsets
`define IOCP_OFS_OUT0_LO      4'h0
`define IOCP_OFS_OUT0_HI      4'h1
`define IOCP_OFS_OUT1_LO      4'h2
`define IOCP_OFS_OUT1_HI      4'h3
`define IOCP_OFS_OUT2_LO      4'h4
`define IOCP_OFS_OUT2_HI      4'h5
`define IOCP_OFS_OUT3_LO      4'h6
`define IOCP_OFS_OUT3_HI      4'h7
`define IOCP_OFS_RELAY_LOW    4'h8
`define IOCP_OFS_RELAY_MID    4'h9
`define IOCP_OFS_RELAY_HIGH   4'ha
`define IOCP_OFS_SOFT_RESET   4'hb
`define IOCP_OFS_CHAN_CTRL    4'hc
`define IOCP_OFS_CONV_START   4'hd
`define IOCP_OFS_ENC_CTRL     4'he
`define IOCP_OFS_WDOG         4'hf

// ==========================================
// field positions
`define IOCP_CH_MEANING_BIT   3
`define IOCP_EN_WDOG_BIT      0
`define IOCP_EN_OUT_BIT       1
`define IOCP_ENC_OP_BIT       2
`define IOCP_ST_WDOG_BIT      4
`define IOCP_ST_UNI_BIT       3
`define IOCP_ST_OUT_EN_BIT    2
`define IOCP_ST_BUSY_BIT      1
`define IOCP_ST_FAULT_BIT     0

// ==========================================
// reset values
`define IOCP_RST_BYTE         8'h00
`define IOCP_RST_NIBBLE       4'h0
`define IOCP_RST_WORD12       12'h000
`define IOCP_RST_WORD16       16'h0000

// ==========================================
// timing
`define IOCP_CLK_HZ           10000000
`define IOCP_CONV_TIME_NS     9000
`define IOCP_CONV_CYCLES      ((`IOCP_CONV_TIME_NS * (`IOCP_CLK_HZ / 1000000)) / 1000)
`define IOCP_WDOG_SHORT_MS    700
`define IOCP_WDOG_LONG_MS     11200
`define IOCP_WDOG_SHORT_CYC   (`IOCP_WDOG_SHORT_MS * (`IOCP_CLK_HZ / 1000))
`define IOCP_WDOG_LONG_CYC    (`IOCP_WDOG_LONG_MS * (`IOCP_CLK_HZ / 1000))

`endif

/* src/iocp_port_map.v */
// register bank of the sixteen-port i/o card, host side is an 8-bit i/o bus
// assumes bus strobes and address are synchronous to clk_sys, one cycle each
`timescale 1ns/1ps
`include "iocp_defs.vh"

module iocp_port_map #(
   parameter [31:0] CONV_CYCLES  = `IOCP_CONV_CYCLES,
   parameter [31:0] WDOG_SHORT   = `IOCP_WDOG_SHORT_CYC,
   parameter [31:0] WDOG_LONG    = `IOCP_WDOG_LONG_CYC
) (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire [7:0]  bus_addr,
   input  wire [7:0]  bus_wdata,
   input  wire        bus_wr,
   input  wire        bus_rd,
   output reg  [7:0]  bus_rdata,
   output wire        bus_sel,
   input  wire [3:0]  base_strap,
   input  wire        polarity_strap,
   input  wire        wdog_short_strap,
   input  wire        card_fault_in,
   output reg  [47:0] analog_out,
   output wire        outputs_enabled_flag,
   output wire [23:0] relay_out,
   input  wire [23:0] relay_in,
   output wire [2:0]  conv_channel,
   output reg         conv_sample,
   input  wire [11:0] conv_data_in,
   input  wire [2:0]  enc_count_up,
   input  wire [2:0]  enc_count_down,
   output wire        watchdog_expired_flag
);

   // ==========================================
   // address decode
   wire [3:0] ofs = bus_addr[3:0];
   assign bus_sel = (bus_addr[7:4] == base_strap);
   wire wr = bus_wr & bus_sel;
   wire rd = bus_rd & bus_sel;

   // soft reset lasts one cycle and reuses the power-up branches
   wire soft_rst = wr & (ofs == `IOCP_OFS_SOFT_RESET);
   wire rst_all = ~reset_n | soft_rst;

   // ==========================================
   // analog output holding and output registers
   reg [7:0] out0_lo_reg;
   reg [7:0] out1_lo_reg;
   reg [7:0] out2_lo_reg;
   reg [7:0] out3_lo_reg;

   reg [3:0] out0_hi_reg;
   reg [3:0] out1_hi_reg;
   reg [3:0] out2_hi_reg;
   reg [3:0] out3_hi_reg;

   // holding kept across soft reset; relays, enables, channel, converter, encoders and watchdog are cleared
   always @(posedge clk_sys) begin
      if (~reset_n) begin
         out0_lo_reg <= `IOCP_RST_BYTE;
         out1_lo_reg <= `IOCP_RST_BYTE;
         out2_lo_reg <= `IOCP_RST_BYTE;
         out3_lo_reg <= `IOCP_RST_BYTE;
         out0_hi_reg <= `IOCP_RST_NIBBLE;
         out1_hi_reg <= `IOCP_RST_NIBBLE;
         out2_hi_reg <= `IOCP_RST_NIBBLE;
         out3_hi_reg <= `IOCP_RST_NIBBLE;
      end else if (wr) begin
         case (ofs)
            `IOCP_OFS_OUT0_LO: out0_lo_reg <= bus_wdata;
            `IOCP_OFS_OUT0_HI: out0_hi_reg <= bus_wdata[3:0];
            `IOCP_OFS_OUT1_LO: out1_lo_reg <= bus_wdata;
            `IOCP_OFS_OUT1_HI: out1_hi_reg <= bus_wdata[3:0];
            `IOCP_OFS_OUT2_LO: out2_lo_reg <= bus_wdata;
            `IOCP_OFS_OUT2_HI: out2_hi_reg <= bus_wdata[3:0];
            `IOCP_OFS_OUT3_LO: out3_lo_reg <= bus_wdata;
            `IOCP_OFS_OUT3_HI: out3_hi_reg <= bus_wdata[3:0];
            default: ;
         endcase
      end
   end

   // all four channels move on one edge, so no channel lags another
   always @(posedge clk_sys) begin
      if (~reset_n) begin
         analog_out <= {4{`IOCP_RST_WORD12}};
      end else if (rd && ofs == `IOCP_OFS_OUT0_LO) begin
         analog_out <= {out3_hi_reg, out3_lo_reg, out2_hi_reg, out2_lo_reg,
                        out1_hi_reg, out1_lo_reg, out0_hi_reg, out0_lo_reg};
      end
   end

   // ==========================================
   // relays and enables
   reg [7:0]  relay_bank_low_reg;
   reg [7:0]  relay_bank_mid_reg;
   reg [7:0]  relay_bank_high_reg;

   reg        wdog_en_reg;
   reg        out_en_reg;
   reg [2:0]  chan_reg;

   // each bank loads all eight channels on one edge, no half-written bank shows
   always @(posedge clk_sys) begin
      if (rst_all) begin
         relay_bank_low_reg <= `IOCP_RST_BYTE;
      end else if (wr && ofs == `IOCP_OFS_RELAY_LOW) begin
         relay_bank_low_reg <= bus_wdata;
      end
   end

   always @(posedge clk_sys) begin
      if (rst_all) begin
         relay_bank_mid_reg <= `IOCP_RST_BYTE;
      end else if (wr && ofs == `IOCP_OFS_RELAY_MID) begin
         relay_bank_mid_reg <= bus_wdata;
      end
   end

   always @(posedge clk_sys) begin
      if (rst_all) begin
         relay_bank_high_reg <= `IOCP_RST_BYTE;
      end else if (wr && ofs == `IOCP_OFS_RELAY_HIGH) begin
         relay_bank_high_reg <= bus_wdata;
      end
   end

   always @(posedge clk_sys) begin
      if (rst_all) begin
         wdog_en_reg <= 1'b0;
         out_en_reg  <= 1'b0;
      end else if (wr && ofs == `IOCP_OFS_CHAN_CTRL && bus_wdata[`IOCP_CH_MEANING_BIT]) begin
         wdog_en_reg <= bus_wdata[`IOCP_EN_WDOG_BIT];
         out_en_reg  <= bus_wdata[`IOCP_EN_OUT_BIT];
      end
   end

   // channel taken at any time; settling before a start is the host's concern
   always @(posedge clk_sys) begin
      if (rst_all) begin
         chan_reg <= 3'h0;
      end else if (wr && ofs == `IOCP_OFS_CHAN_CTRL && !bus_wdata[`IOCP_CH_MEANING_BIT]) begin
         chan_reg <= bus_wdata[2:0];
      end
   end

   assign relay_out = {relay_bank_high_reg, relay_bank_mid_reg, relay_bank_low_reg};
   assign outputs_enabled_flag = out_en_reg;
   assign conv_channel = chan_reg;

   // ==========================================
   // converter sequence
   localparam ST_IDLE = 2'b01;
   localparam ST_CONV = 2'b10;

   reg [1:0]  conv_state_reg;
   reg [15:0] conv_cnt_reg;
   reg [11:0] result_reg;

   always @(posedge clk_sys) begin
      if (rst_all) begin
         conv_state_reg <= ST_IDLE;
         conv_cnt_reg   <= 16'h0000;
         conv_sample    <= 1'b0;
      end else begin
         conv_sample <= 1'b0;
         case (conv_state_reg)
            ST_IDLE: begin
               if (wr && ofs == `IOCP_OFS_CONV_START) begin
                  conv_state_reg <= ST_CONV;
                  conv_cnt_reg   <= CONV_CYCLES[15:0] - 16'h0001;
                  conv_sample    <= 1'b1;
               end
            end
            ST_CONV: begin
               // a second start during busy is ignored
               if (conv_cnt_reg == 16'h0000) begin
                  conv_state_reg <= ST_IDLE;
               end else begin
                  conv_cnt_reg <= conv_cnt_reg - 16'h0001;
               end
            end
            default: conv_state_reg <= ST_IDLE;
         endcase
      end
   end
   wire busy = conv_state_reg[1];
   wire conv_done = busy && (conv_cnt_reg == 16'h0000);

   // result held until the next conversion ends, so reads in between stay paired
   always @(posedge clk_sys) begin
      if (rst_all) begin
         result_reg <= `IOCP_RST_WORD12;
      end else if (conv_done) begin
         result_reg <= conv_data_in;
      end
   end

   // ==========================================
   // encoder counters
   reg  [15:0] enc_latch_reg;
   wire [1:0]  pick = bus_wdata[1] ? 2'd2 : {1'b0, bus_wdata[0]};
   wire        enc_wr = wr & (ofs == `IOCP_OFS_ENC_CTRL);
   wire [47:0] enc_cnt_all;
   genvar      g;

   // count enables stand in for quadrature; both at once cancel
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_enc
         reg  [15:0] cnt_reg;
         wire        clr_hit = enc_wr & bus_wdata[`IOCP_ENC_OP_BIT] & ({30'h0, pick} == g);

         always @(posedge clk_sys) begin
            if (rst_all) begin
               cnt_reg <= `IOCP_RST_WORD16;
            end else if (clr_hit) begin
               cnt_reg <= `IOCP_RST_WORD16;
            end else if (enc_count_up[g] && !enc_count_down[g]) begin
               cnt_reg <= cnt_reg + 16'h0001;
            end else if (enc_count_down[g] && !enc_count_up[g]) begin
               cnt_reg <= cnt_reg - 16'h0001;
            end
         end
         assign enc_cnt_all[g*16 +: 16] = cnt_reg;
      end
   endgenerate

   // one shared latch: both byte reads see the same capture
   always @(posedge clk_sys) begin
      if (rst_all) begin
         enc_latch_reg <= `IOCP_RST_WORD16;
      end else if (enc_wr && !bus_wdata[`IOCP_ENC_OP_BIT]) begin
         enc_latch_reg <= enc_cnt_all[pick*16 +: 16];
      end
   end

   // ==========================================
   // watchdog
   reg  [31:0] wdog_cnt_reg;
   reg         wdog_exp_reg;
   wire [31:0] wdog_len = wdog_short_strap ? WDOG_SHORT : WDOG_LONG;
   wire        wdog_restart = wr && (ofs == `IOCP_OFS_WDOG);
   wire        wdog_end = wdog_cnt_reg >= wdog_len - 32'h00000001;

   // counter runs only while enabled; restart and disable both start it over
   always @(posedge clk_sys) begin
      if (rst_all) begin
         wdog_cnt_reg <= 32'h00000000;
      end else if (!wdog_en_reg || wdog_restart) begin
         wdog_cnt_reg <= 32'h00000000;
      end else if (!wdog_end) begin
         wdog_cnt_reg <= wdog_cnt_reg + 32'h00000001;
      end
   end

   // expired flag is sticky: only a card reset clears it, a restart does not
   always @(posedge clk_sys) begin
      if (rst_all) begin
         wdog_exp_reg <= 1'b0;
      end else if (wdog_en_reg && !wdog_restart && wdog_end) begin
         wdog_exp_reg <= 1'b1;
      end
   end
   assign watchdog_expired_flag = wdog_exp_reg;

   // ==========================================
   // read data, registered; upper status bits read as zero
   // status bit positions follow the shared field map
   reg [7:0] status;
   always @* begin
      status = `IOCP_RST_BYTE;
      status[`IOCP_ST_WDOG_BIT]   = wdog_exp_reg;
      status[`IOCP_ST_UNI_BIT]    = polarity_strap;
      status[`IOCP_ST_OUT_EN_BIT] = out_en_reg;
      status[`IOCP_ST_BUSY_BIT]   = busy;
      status[`IOCP_ST_FAULT_BIT]  = card_fault_in;
   end

   // high nibble frozen at the low-byte read, so a pair never mixes two results
   reg [3:0] res_hi_reg;
   always @(posedge clk_sys) begin
      if (rst_all) begin
         res_hi_reg <= `IOCP_RST_NIBBLE;
      end else if (rd && ofs == `IOCP_OFS_CHAN_CTRL) begin
         res_hi_reg <= result_reg[11:8];
      end
   end

   always @(posedge clk_sys) begin
      if (~reset_n) begin
         bus_rdata <= `IOCP_RST_BYTE;
      end else if (rd) begin
         case (ofs)
            `IOCP_OFS_RELAY_LOW:  bus_rdata <= relay_in[7:0];
            `IOCP_OFS_RELAY_MID:  bus_rdata <= relay_in[15:8];
            `IOCP_OFS_SOFT_RESET: bus_rdata <= status;
            `IOCP_OFS_CHAN_CTRL:  bus_rdata <= result_reg[7:0];
            `IOCP_OFS_CONV_START: bus_rdata <= {4'h0, res_hi_reg};
            `IOCP_OFS_ENC_CTRL:   bus_rdata <= enc_latch_reg[7:0];
            `IOCP_OFS_WDOG:       bus_rdata <= enc_latch_reg[15:8];
            `IOCP_OFS_OUT0_LO:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_OUT0_HI:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_OUT1_LO:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_OUT1_HI:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_OUT2_LO:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_OUT2_HI:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_OUT3_LO:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_OUT3_HI:    bus_rdata <= `IOCP_RST_BYTE;
            `IOCP_OFS_RELAY_HIGH: bus_rdata <= `IOCP_RST_BYTE;
            default:              bus_rdata <= `IOCP_RST_BYTE;
         endcase
      end
   end

endmodule

/* tb/iocp_front_model.sv */
// far-side model: converter data and relay pin readback
// assumes conv_sample is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
module iocp_front_model (
   input  wire        clk_sys,
   input  wire        conv_sample,
   input  wire [2:0]  conv_channel,
   input  wire [23:0] relay_out,
   output reg  [11:0] conv_data_in,
   output wire [23:0] relay_in
);
   reg [7:0] hold;
   initial begin
      hold = 8'h00;
      conv_data_in = 12'h000;
   end
   // ==========================================
   // code stands only through a conversion, then toggles so a late sample shows
   always @(posedge clk_sys) begin
      if (conv_sample) begin
         hold <= 8'd100;
         conv_data_in <= {9'h1f0, conv_channel};
      end else if (hold != 8'h00) begin
         hold <= hold - 8'h01;
      end else begin
         conv_data_in <= ~conv_data_in;
      end
   end
   assign relay_in = relay_out;
endmodule

/* tb/iocp_port_map_properties.sv */
// concurrent checks on the port map, bound to its top module
// assumes one-cycle bus strobes and sync active-low reset
`timescale 1ns/1ps
module iocp_port_map_chk (
   input wire        clk_sys,
   input wire        reset_n,
   input wire [7:0]  bus_addr,
   input wire [7:0]  bus_wdata,
   input wire        bus_wr,
   input wire        bus_rd,
   input wire [7:0]  bus_rdata,
   input wire        bus_sel,
   input wire [3:0]  base_strap,
   input wire        polarity_strap,
   input wire [47:0] analog_out,
   input wire        outputs_enabled_flag,
   input wire [23:0] relay_out,
   input wire [23:0] relay_in,
   input wire [2:0]  conv_channel,
   input wire        conv_sample,
   input wire        watchdog_expired_flag
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire       wr_hit = bus_wr && bus_sel;
   wire       rd_hit = bus_rd && bus_sel;
   wire [3:0] ofs    = bus_addr[3:0];
   // ==========================================
   // assertions
   sel_decode_a: assert property (bus_sel == (bus_addr[7:4] == base_strap))
      else $error("decode hit wrong");
   relay_set_a: assert property (wr_hit && ofs == 4'h9 |=> relay_out[15:8] == $past(bus_wdata))
      else $error("relay bank not set");
   relay_read_a: assert property (rd_hit && ofs == 4'h8 |=> bus_rdata == $past(relay_in[7:0]))
      else $error("relay readback wrong");
   out_hold_a: assert property (!(rd_hit && ofs == 4'h0) |=> $stable(analog_out))
      else $error("outputs moved without update read");
   soft_reset_a: assert property (wr_hit && ofs == 4'hb |=> relay_out == 24'h0 && !outputs_enabled_flag
      && !watchdog_expired_flag)
      else $error("soft reset incomplete");
   en_store_a: assert property (wr_hit && ofs == 4'hc && bus_wdata[3] |=>
      outputs_enabled_flag == $past(bus_wdata[1]) && $stable(conv_channel))
      else $error("enable store wrong");
   chan_store_a: assert property (wr_hit && ofs == 4'hc && !bus_wdata[3] |=>
      conv_channel == $past(bus_wdata[2:0]) && $stable(outputs_enabled_flag))
      else $error("channel store wrong");
   start_cause_a: assert property (conv_sample |-> $past(wr_hit) && $past(ofs) == 4'hd)
      else $error("conversion started unasked");
   start_pulse_a: assert property (conv_sample |=> !conv_sample [*8])
      else $error("start pulse repeated");
   status_bits_a: assert property (rd_hit && ofs == 4'hb |=>
      bus_rdata[7:5] == 3'h0 && bus_rdata[3] == $past(polarity_strap))
      else $error("status byte wrong");
   cover property (conv_sample);
   cover property (wr_hit && ofs == 4'hb);
   cover property (rd_hit && ofs == 4'h0);
endmodule
bind iocp_port_map iocp_port_map_chk chk (.*);

/* tb/tb_top.sv */
// self-checking bench for the sixteen-port card register map
// assumes the front model and checker compile alongside
`timescale 1ns/1ps
module tb_top;
   localparam [7:0] B = 8'h50;
   reg        clk_sys, reset_n, bus_wr, bus_rd, polarity_strap, wdog_short_strap, card_fault_in;
   reg  [7:0] bus_addr, bus_wdata, d, i, j;
   reg  [3:0] base_strap;
   reg  [2:0] enc_count_up, enc_count_down;
   wire [7:0] bus_rdata;
   wire       bus_sel, outputs_enabled_flag, conv_sample, watchdog_expired_flag;
   wire [47:0] analog_out;
   wire [23:0] relay_out, relay_in;
   wire [11:0] conv_data_in;
   wire [2:0]  conv_channel;
   integer    mismatches, checks;
   // short watchdog counts keep the run brief
   iocp_port_map #(.WDOG_SHORT(20), .WDOG_LONG(40)) dut (.*);
   iocp_front_model fm (.*);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // ==========================================
   // bus tasks
   task tick; begin @(posedge clk_sys); #1; end endtask
   task wr(input [7:0] a, input [7:0] v); begin
      bus_addr = a; bus_wdata = v; bus_wr = 1'b1; tick; bus_wr = 1'b0; tick;
   end endtask
   task rd(input [7:0] a, output [7:0] v); begin
      bus_addr = a; bus_rd = 1'b1; tick; bus_rd = 1'b0; v = bus_rdata; tick;
   end endtask
   task chk(input [47:0] g, input [47:0] e); begin
      checks = checks + 1;
      if (g !== e) begin
         mismatches = mismatches + 1;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   end endtask
   task close_out; begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   end endtask
   // ==========================================
   // tests
   initial begin
      {bus_wr, bus_rd, enc_count_up, enc_count_down, card_fault_in, bus_addr, bus_wdata} = 0;
      {polarity_strap, wdog_short_strap, base_strap, reset_n} = 7'h2a;
      mismatches = 0;
      checks = 0;
      repeat (20) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      for (i = 0; i < 8'h04; i = i + 1) begin
         wr(B + 8'h02 * i, 8'h10 + i);
         wr(B + 8'h02 * i + 8'h01, 8'hf0 + i);
      end
      chk(analog_out, 48'h0);
      rd(B, d); chk(analog_out, 48'h313212111010);
      wr(B + 8'h08, 8'ha5); wr(B + 8'h09, 8'h3c); wr(B + 8'h0a, 8'h81); wr(8'h68, 8'hff);
      chk(relay_out, 24'h813ca5);
      rd(B + 8'h08, d); chk(d, 8'ha5);
      rd(B + 8'h09, d); chk(d, 8'h3c);
      wr(B + 8'h0c, 8'h0a); wr(B + 8'h0c, 8'h05);
      chk({outputs_enabled_flag, conv_channel}, 4'hd);
      for (i = 0; i < 8'h02; i = i + 1) begin
         polarity_strap = i[0];
         card_fault_in = i[0];
         wr(B + 8'h0d, 8'h00); rd(B + 8'h0b, d);
         chk(d[3:0], {i[0], 2'b11, i[0]});
         for (j = 0; d[1] && j < 8'd100; j = j + 1) rd(B + 8'h0b, d);
         chk({d[1], j > 8'd40, j < 8'd50}, 3'b011);
         rd(B + 8'h0c, d); chk(d, 8'h85);
         rd(B + 8'h0d, d); chk(d, 8'h0f);
      end
      for (i = 0; i < 8'h03; i = i + 1) begin
         enc_count_up[i] = 1'b1;
         repeat (i + 1) tick;
         enc_count_up[i] = 1'b0;
         wr(B + 8'h0e, {6'h0, i[1], i[1] | i[0]});
         rd(B + 8'h0e, d); chk(d, i + 8'h01);
         rd(B + 8'h0f, d); chk(d, 8'h00);
      end
      wr(B + 8'h0e, 8'h05); wr(B + 8'h0e, 8'h01); rd(B + 8'h0e, d); chk(d, 8'h00);
      wr(B + 8'h0c, 8'h0b);
      repeat (4) begin repeat (6) tick; wr(B + 8'h0f, 8'h00); end
      chk(watchdog_expired_flag, 1'b0);
      repeat (25) tick;
      chk(watchdog_expired_flag, 1'b1); rd(B + 8'h0b, d); chk(d[4], 1'b1);
      wr(B + 8'h0b, 8'h00); chk({relay_out, outputs_enabled_flag, watchdog_expired_flag}, 26'h0);
      chk(analog_out, 48'h313212111010);
      rd(B + 8'h03, d); chk(d, 8'h00);
      wdog_short_strap = 1'b0; wr(B + 8'h0c, 8'h09); repeat (30) tick; chk(watchdog_expired_flag, 1'b0);
      repeat (15) tick; chk(watchdog_expired_flag, 1'b1);
      close_out;
   end
   // hang guard well beyond the few hundred cycles the tests take
   initial begin
      repeat (3000) @(posedge clk_sys);
      mismatches = mismatches + 1;
      close_out;
   end
endmodule
